// file: common/dtcrm_pkg.sv
/*
 * dtcrm_pkg: register map, field positions and reset values
 * of the dual timer capture/reload module.
 * assumes: a single system clock; registers reached over a plain port.
 */
package dtcrm_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [3:0] OFF_AUX_CTRL  = 4'h0;
    localparam logic [3:0] OFF_CORE_CTRL = 4'h1;
    localparam logic [3:0] OFF_AUX_CNT   = 4'h2;
    localparam logic [3:0] OFF_CORE_CNT  = 4'h3;
    localparam logic [3:0] OFF_CAPTURE_RELOAD_REG    = 4'h4;
    localparam logic [3:0] OFF_CAP_CTRL  = 4'h5;
    localparam logic [3:0] OFF_IRQ_STAT  = 4'h6;
    localparam logic [3:0] OFF_IRQ_MASK  = 4'h7;

    // ----------------------------------------------------------------
    // timer control fields (aux and core share the layout)
    // ----------------------------------------------------------------
    localparam int unsigned TC_RUN    = 0;
    localparam int unsigned TC_DOWN   = 1;
    localparam int unsigned TC_PINDIR = 2;
    localparam int unsigned TC_EXTCLK = 3;
    localparam int unsigned TC_EDGE_L = 4;  // 2 bits: 01 rise 10 fall 11 both
    localparam int unsigned TC_PRE_L  = 6;  // 3 bits: prescale 2^(n+1)
    localparam int unsigned TC_OTLCLK = 9;  // aux: count on toggle latch
    localparam int unsigned TC_RELOAD = 10; // core: reload on over/underflow
    localparam int unsigned TC_OUTEN  = 11; // core: latch drives pin

    // capture control fields
    localparam int unsigned CC_EDGE_L = 0;  // 2 bits on capture pin
    localparam int unsigned CC_CLR    = 2;
    localparam int unsigned CC_OCNT   = 3;
    localparam int unsigned CC_ODIR   = 4;

    // interrupt status fields
    localparam int unsigned IRQ_AUX  = 0;
    localparam int unsigned IRQ_CORE = 1;
    localparam int unsigned IRQ_CAP  = 2;
    localparam int unsigned IRQ_W    = 3;

    localparam logic [15:0] CTRL_RST   = 16'h0000;
    localparam logic [15:0] CNT_RST    = 16'h0000;
    localparam logic [15:0] CNT_ONE    = 16'h0001;
    localparam logic [15:0] CNT_MAX    = 16'hFFFF;
    localparam logic [2:0]  IRQ_RST    = 3'h0;
    localparam logic [1:0]  EDGE_RISE  = 2'h1;
    localparam logic [1:0]  EDGE_FALL  = 2'h2;

    // minimum spacing of count steps in system clocks
    localparam int unsigned MIN_STEP_CYC = 2;
    localparam int unsigned PRE_W        = 8;

endpackage

// file: rtl/dtcrm_timer.sv
/*
 * dtcrm_timer: one 16-bit up/down timer with prescaler, external edge
 * count, load port and wrap event.
 * assumes: synchronous inputs already edge-detected by the caller.
 */
`timescale 1ns/10ps
module dtcrm_timer
    import dtcrm_pkg::*;
#(
    parameter int unsigned W = 16
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    // configuration
    input  wire logic         run_i,
    input  wire logic         down_i,
    input  wire logic         ext_i,
    input  wire logic [2:0]   pre_i,
    input  wire logic         ext_step_i,
    // loads
    input  wire logic         load_i,
    input  wire logic [W-1:0] load_val_i,
    // state
    output logic      [W-1:0] cnt_o,
    output logic              wrap_o
);

    typedef struct packed {
        logic [W-1:0]     cnt;
        logic [PRE_W-1:0] pre;
        logic             gap;
        logic             wrap;
    } dtcrm_tmr_t;

    dtcrm_tmr_t st_ff;
    dtcrm_tmr_t nxt_st;
    logic       step;
    logic       tick;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.wrap = 1'b0;
        nxt_st.pre = st_ff.pre + 1'b1;
        // prescale by 2^(n+1): the least period is two clocks
        tick = (st_ff.pre[pre_i] != nxt_st.pre[pre_i]) && nxt_st.pre[pre_i]
               == 1'b0;
        // external steps also need one idle cycle between them
        step = run_i && (ext_i ? (ext_step_i && !st_ff.gap) : tick);
        nxt_st.gap = step;
        if (load_i) begin
            nxt_st.cnt = load_val_i;
        end else if (step) begin
            nxt_st.cnt = down_i ? st_ff.cnt - 1'b1 : st_ff.cnt + 1'b1;
            nxt_st.wrap = down_i ? (st_ff.cnt == '0) : (&st_ff.cnt);
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign cnt_o  = st_ff.cnt;
    assign wrap_o = st_ff.wrap;

    step_spacing_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i) step |=> !step)
        else $error("count steps closer than two clocks");

endmodule

// file: rtl/dtcrm_top.sv
/*
 * dtcrm_top: dual timer capture/reload module with an aux timer, a core
 * timer, a shared capture/reload register and a toggle latch.
 * assumes: one system clock; pins synchronous to it; register port with
 * read data one cycle after the read strobe.
 */
// Strobed register access and the register offsets were chosen for this implementation.
// Notes on behaviour
// - count steps at least two clocks apart
// - two timers share one capture/reload register
// - all sixteen bits wide, wrapping both ways
// - count prescaled clock or external edges
// - direction from control bit or pin
// - toggle latch inverts on core wrap
// - latch clocks aux timer and/or drives pin
// - core wrap pulses clock compare unit timers
// - core wrap reloads from capture/reload register
// - capture pin edge copies aux value
// - optional aux clear right after capture
// - other module count/direction edges also capture
`timescale 1ns/10ps
module dtcrm_top
    import dtcrm_pkg::*;
(
    // clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              rst_b_i,
    // register port
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    // timer pins
    input  wire logic              aux_count_pin_i,
    input  wire logic              core_count_pin_i,
    input  wire logic              aux_direction_input_pin_i,
    input  wire logic              core_direction_input_pin_i,
    input  wire logic              capture_input_pin_i,
    input  wire logic              other_module_count_input_i,
    input  wire logic              other_module_direction_input_i,
    // outputs
    output logic                   toggle_latch_out_pin_o,
    output logic                   compare_unit_clk_o,
    output logic                   irq_o
);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_ff;
    logic       rst_b;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_ff[1];

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    localparam int unsigned NPIN = 7;

    typedef struct packed {
        logic [NPIN-1:0]   s1;
        logic [NPIN-1:0]   s2;
        logic [NPIN-1:0]   s3;
        logic [15:0]       aux_ctrl;
        logic [15:0]       core_ctrl;
        logic [15:0]       cap_ctrl;
        logic [15:0]       capture_reload_reg;
        logic              latch;
        logic              cmp_clk;
        logic              clr_pend;
        logic [IRQ_W-1:0]  stat;
        logic [IRQ_W-1:0]  mask;
        logic [DATA_W-1:0] rdata;
        logic              irq;
        logic              pin;
    } dtcrm_st_t;

    dtcrm_st_t st_ff;
    dtcrm_st_t nxt_st;

    logic [15:0] aux_cnt;
    logic [15:0] core_cnt;
    logic        aux_wrap;
    logic        core_wrap;
    logic        aux_load;
    logic        core_load;
    logic [15:0] aux_load_val;
    logic [15:0] core_load_val;
    logic        aux_step_src;
    logic        core_step_src;
    logic [NPIN-1:0] pins;
    logic [NPIN-1:0] rise;
    logic [NPIN-1:0] fall;
    logic        capture;

    // edge select: 01 rising, 10 falling, 11 both
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic r, input logic f);
        edge_hit = (sel[0] && r) || (sel[1] && f);
    endfunction

    function automatic logic any_edge(input logic r, input logic f);
        any_edge = r || f;
    endfunction

    assign pins = {other_module_direction_input_i,
                   other_module_count_input_i,
                   capture_input_pin_i,
                   core_direction_input_pin_i,
                   aux_direction_input_pin_i,
                   core_count_pin_i,
                   aux_count_pin_i};

    // edges compare the second and third stages: s1 feeds s2 alone
    assign rise = st_ff.s2 & ~st_ff.s3;
    assign fall = ~st_ff.s2 & st_ff.s3;

    // ----------------------------------------------------------------
    // timers
    // ----------------------------------------------------------------
    logic aux_down;
    logic core_down;
    logic latch_edge;

    assign aux_down  = st_ff.aux_ctrl[TC_PINDIR] ? st_ff.s3[2]
                     : st_ff.aux_ctrl[TC_DOWN];
    assign core_down = st_ff.core_ctrl[TC_PINDIR] ? st_ff.s3[3]
                     : st_ff.core_ctrl[TC_DOWN];

    // latch as aux clock: any state change of the latch counts
    assign latch_edge = core_wrap;
    assign aux_step_src = st_ff.aux_ctrl[TC_OTLCLK] ? latch_edge
        : edge_hit(st_ff.aux_ctrl[TC_EDGE_L +: 2], rise[0], fall[0]);
    assign core_step_src =
        edge_hit(st_ff.core_ctrl[TC_EDGE_L +: 2], rise[1], fall[1]);

    assign capture =
        edge_hit(st_ff.cap_ctrl[CC_EDGE_L +: 2], rise[4], fall[4])
        || (st_ff.cap_ctrl[CC_OCNT] && any_edge(rise[5], fall[5]))
        || (st_ff.cap_ctrl[CC_ODIR] && any_edge(rise[6], fall[6]));

    always_comb begin
        aux_load = 1'b0;
        aux_load_val = CNT_RST;
        core_load = 1'b0;
        core_load_val = st_ff.capture_reload_reg;
        if (wr_i && addr_i == OFF_AUX_CNT) begin
            aux_load = 1'b1;
            aux_load_val = wdata_i;
        end else if (st_ff.clr_pend) begin
            aux_load = 1'b1;
        end
        if (wr_i && addr_i == OFF_CORE_CNT) begin
            core_load = 1'b1;
            core_load_val = wdata_i;
        end else if (core_wrap && st_ff.core_ctrl[TC_RELOAD]) begin
            core_load = 1'b1;
        end
    end

    // two timers and one shared register
    dtcrm_timer #(
        .W (DATA_W)
    ) u_aux (
        .clk_i      (sys_clk_i),
        .rst_b_i    (rst_b),
        .run_i      (st_ff.aux_ctrl[TC_RUN]),
        .down_i     (aux_down),
        .ext_i      (st_ff.aux_ctrl[TC_EXTCLK] || st_ff.aux_ctrl[TC_OTLCLK]),
        .pre_i      (st_ff.aux_ctrl[TC_PRE_L +: 3]),
        .ext_step_i (aux_step_src),
        .load_i     (aux_load),
        .load_val_i (aux_load_val),
        .cnt_o      (aux_cnt),
        .wrap_o     (aux_wrap)
    );

    dtcrm_timer #(
        .W (DATA_W)
    ) u_core (
        .clk_i      (sys_clk_i),
        .rst_b_i    (rst_b),
        .run_i      (st_ff.core_ctrl[TC_RUN]),
        .down_i     (core_down),
        .ext_i      (st_ff.core_ctrl[TC_EXTCLK]),
        .pre_i      (st_ff.core_ctrl[TC_PRE_L +: 3]),
        .ext_step_i (core_step_src),
        .load_i     (core_load),
        .load_val_i (core_load_val),
        .cnt_o      (core_cnt),
        .wrap_o     (core_wrap)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = pins;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        nxt_st.cmp_clk = core_wrap;
        nxt_st.clr_pend = capture && st_ff.cap_ctrl[CC_CLR];
        if (core_wrap) begin
            nxt_st.latch = ~st_ff.latch;
        end
        if (wr_i) begin
            if (addr_i == OFF_AUX_CTRL) begin
                nxt_st.aux_ctrl = wdata_i;
            end else if (addr_i == OFF_CORE_CTRL) begin
                nxt_st.core_ctrl = wdata_i;
            end else if (addr_i == OFF_CAPTURE_RELOAD_REG) begin
                nxt_st.capture_reload_reg = wdata_i;
            end else if (addr_i == OFF_CAP_CTRL) begin
                nxt_st.cap_ctrl = wdata_i;
            end else if (addr_i == OFF_IRQ_STAT) begin
                nxt_st.stat = st_ff.stat & ~wdata_i[IRQ_W-1:0];
            end else if (addr_i == OFF_IRQ_MASK) begin
                nxt_st.mask = wdata_i[IRQ_W-1:0];
            end
        end
        if (capture) begin
            nxt_st.capture_reload_reg = aux_cnt;
        end
        // set wins over a same-cycle clear
        if (aux_wrap) begin
            nxt_st.stat[IRQ_AUX] = 1'b1;
        end
        if (core_wrap) begin
            nxt_st.stat[IRQ_CORE] = 1'b1;
        end
        if (capture) begin
            nxt_st.stat[IRQ_CAP] = 1'b1;
        end
        nxt_st.irq = |(nxt_st.stat & nxt_st.mask);
        nxt_st.pin = nxt_st.latch && nxt_st.core_ctrl[TC_OUTEN];
        nxt_st.rdata = '0;
        if (rd_i) begin
            if (addr_i == OFF_AUX_CTRL) begin
                nxt_st.rdata = st_ff.aux_ctrl;
            end else if (addr_i == OFF_CORE_CTRL) begin
                nxt_st.rdata = st_ff.core_ctrl;
            end else if (addr_i == OFF_AUX_CNT) begin
                nxt_st.rdata = aux_cnt;
            end else if (addr_i == OFF_CORE_CNT) begin
                nxt_st.rdata = core_cnt;
            end else if (addr_i == OFF_CAPTURE_RELOAD_REG) begin
                nxt_st.rdata = st_ff.capture_reload_reg;
            end else if (addr_i == OFF_CAP_CTRL) begin
                nxt_st.rdata = st_ff.cap_ctrl;
            end else if (addr_i == OFF_IRQ_STAT) begin
                nxt_st.rdata = {{(DATA_W-IRQ_W){1'b0}}, st_ff.stat};
            end else if (addr_i == OFF_IRQ_MASK) begin
                nxt_st.rdata = {{(DATA_W-IRQ_W){1'b0}}, st_ff.mask};
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign toggle_latch_out_pin_o = st_ff.pin;
    assign compare_unit_clk_o     = st_ff.cmp_clk;
    assign irq_o                  = st_ff.irq;
    assign rdata_o                = st_ff.rdata;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    latch_toggle_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b)
        core_wrap |=> st_ff.latch != $past(st_ff.latch))
        else $error("toggle latch did not invert on core wrap");

    cmp_clock_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b)
        core_wrap |=> compare_unit_clk_o)
        else $error("compare clock missing after core wrap");

    core_reload_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b)
        core_wrap && st_ff.core_ctrl[TC_RELOAD] && !wr_i
        |=> core_cnt == $past(st_ff.capture_reload_reg))
        else $error("core timer not reloaded from capture register");

    cap_copy_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b)
        capture |=> st_ff.capture_reload_reg == $past(aux_cnt))
        else $error("capture did not copy aux timer");

    cap_clear_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b)
        capture && st_ff.cap_ctrl[CC_CLR] && !wr_i ##1 !wr_i
        |=> aux_cnt == CNT_RST)
        else $error("aux timer not cleared after capture");

    irq_flag_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b)
        capture ##1 st_ff.mask[IRQ_CAP] |-> irq_o)
        else $error("capture flag did not raise interrupt");

    other_cap_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b)
        st_ff.cap_ctrl[CC_OCNT] && rise[5]
        |=> st_ff.capture_reload_reg == $past(aux_cnt))
        else $error("other module count edge did not capture");

    aux_wrap_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b)
        aux_wrap && !$past(aux_down) |-> aux_cnt == CNT_RST)
        else $error("aux overflow did not wrap to zero");

endmodule

// file: tb/dtcrm_far_model.sv
/*
 * dtcrm_far_model: behavioural model of the far side of the timer pins,
 * the event sources, direction lines and neighbouring timer inputs.
 * assumes: driven from the bench through its tasks; pins are push-pull
 * levels that change only just after a rising clock edge.
 */
`timescale 1ns/10ps
module dtcrm_far_model (
    // clock
    input  wire logic       clk_i,
    // pins: 0 aux cnt 1 core cnt 2 aux dir 3 core dir 4 cap 5 ocnt 6 odir
    output logic      [6:0] pins_o
);
    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------
    initial begin
        pins_o = 7'h00;
    end

    // level change, then hold for gap cycles so steps stay apart
    task automatic set_pin(input int idx, input logic val, input int gap);
        @(posedge clk_i);
        pins_o[idx] <= val;
        repeat (gap) @(posedge clk_i);
    endtask

    // one rising and one falling transition
    task automatic pulse(input int idx, input int gap);
        set_pin(idx, 1'b1, gap);
        set_pin(idx, 1'b0, gap);
    endtask
endmodule

// file: tb/tb.sv
/*
 * tb: self-checking bench of the dual timer capture/reload module.
 * assumes: the register port of the design top and a far-side pin model.
 */
`timescale 1ns/10ps
module tb;
    import dtcrm_pkg::*;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic              sys_clk_i;
    logic              rst_b_i;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wdata_i;
    logic              wr_i;
    logic              rd_i;
    logic [DATA_W-1:0] rdata_o;
    logic [6:0]        pins;
    logic              latch_pin;
    logic              cmp_clk;
    logic              irq_o;
    logic [15:0]       v;
    logic [15:0]       a;
    logic [15:0]       b;
    logic [15:0]       cc;
    int                bad_count   = 0;
    int                checks_done = 0;
    int                cmp_pulses  = 0;

    dtcrm_top DUT (
        .sys_clk_i                      (sys_clk_i),
        .rst_b_i                        (rst_b_i),
        .addr_i                         (addr_i),
        .wdata_i                        (wdata_i),
        .wr_i                           (wr_i),
        .rd_i                           (rd_i),
        .rdata_o                        (rdata_o),
        .aux_count_pin_i                (pins[0]),
        .core_count_pin_i               (pins[1]),
        .aux_direction_input_pin_i      (pins[2]),
        .core_direction_input_pin_i     (pins[3]),
        .capture_input_pin_i            (pins[4]),
        .other_module_count_input_i     (pins[5]),
        .other_module_direction_input_i (pins[6]),
        .toggle_latch_out_pin_o         (latch_pin),
        .compare_unit_clk_o             (cmp_clk),
        .irq_o                          (irq_o)
    );

    dtcrm_far_model far_u (
        .clk_i  (sys_clk_i),
        .pins_o (pins)
    );

    // ----------------------------------------------------------------
    // clock, pulse counter, watchdog
    // ----------------------------------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i) begin
        if (cmp_clk === 1'b1) cmp_pulses <= cmp_pulses + 1;
    end

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        bad_count++;
        final_report();
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    function automatic logic [15:0] bit_of(input int unsigned p);
        return 16'h0001 << p;
    endfunction

    task automatic wr(input logic [ADDR_W-1:0] ad, input logic [15:0] d);
        @(posedge sys_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= ad;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] ad, output logic [15:0] d);
        @(posedge sys_clk_i);
        rd_i   <= 1'b1;
        addr_i <= ad;
        @(posedge sys_clk_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask

    task automatic cmp16(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask

    task automatic cmp1(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            $display("BAD %s expected %b seen %b", nm, e, g);
            bad_count++;
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        rst_b_i = 1'b0;
        addr_i  = 4'h0;
        wdata_i = 16'h0000;
        wr_i    = 1'b0;
        rd_i    = 1'b0;
        repeat (16) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        // reset values and unmapped index
        for (int i = 0; i < 8; i++) begin
            rd(4'(i), v);
            cmp16("reset value", CTRL_RST, v);
        end
        cmp1("latch pin reset", 1'b0, latch_pin);
        cmp1("irq reset", 1'b0, irq_o);
        wr(4'h8, 16'hFFFF);
        rd(4'h8, v);
        cmp16("unmapped", 16'h0000, v);
        // prescaled clock, period 2^(n+1) clocks over 20 cycles
        for (int n = 0; n < 2; n++) begin
            wr(OFF_CORE_CTRL, bit_of(TC_RUN) | 16'(n << TC_PRE_L));
            repeat (10) @(posedge sys_clk_i);
            rd(OFF_CORE_CNT, a);
            repeat (18) @(posedge sys_clk_i);
            rd(OFF_CORE_CNT, b);
            cmp16("prescaled steps", 16'(20 >> (n + 1)), b - a);
        end
        wr(OFF_CORE_CTRL, CTRL_RST);
        // external count, overflow with reload, latch, aux on latch
        cc = bit_of(TC_RUN) | bit_of(TC_EXTCLK) | bit_of(TC_RELOAD)
           | bit_of(TC_OUTEN) | ({14'h0000, EDGE_RISE} << TC_EDGE_L);
        wr(OFF_CAPTURE_RELOAD_REG, 16'h1234);
        wr(OFF_CORE_CNT, 16'hFFFE);
        wr(OFF_IRQ_MASK, 16'h0002);
        wr(OFF_AUX_CNT, CNT_RST);
        wr(OFF_AUX_CTRL, bit_of(TC_RUN) | bit_of(TC_OTLCLK));
        wr(OFF_CORE_CTRL, cc);
        far_u.pulse(1, 6);
        rd(OFF_CORE_CNT, v);
        cmp16("core up", CNT_MAX, v);
        far_u.pulse(1, 6);
        rd(OFF_CORE_CNT, v);
        cmp16("core reload", 16'h1234, v);
        cmp1("latch pin", 1'b1, latch_pin);
        cmp1("irq core", 1'b1, irq_o);
        cmp16("compare clocks", 16'h0001, 16'(cmp_pulses));
        rd(OFF_AUX_CNT, v);
        cmp16("aux on latch", CNT_ONE, v);
        rd(OFF_IRQ_STAT, v);
        cmp16("status core", 16'h0002, v);
        // underflow with direction from the pin
        far_u.set_pin(3, 1'b1, 2);
        wr(OFF_CORE_CTRL, cc | bit_of(TC_PINDIR));
        wr(OFF_CORE_CNT, CNT_RST);
        far_u.pulse(1, 6);
        rd(OFF_CORE_CNT, v);
        cmp16("underflow reload", 16'h1234, v);
        cmp1("latch back", 1'b0, latch_pin);
        cmp16("compare clocks", 16'h0002, 16'(cmp_pulses));
        rd(OFF_AUX_CNT, v);
        cmp16("aux second", 16'h0002, v);
        // software direction ignores the pin
        far_u.set_pin(3, 1'b0, 2);
        wr(OFF_CORE_CTRL, cc | bit_of(TC_DOWN));
        wr(OFF_CORE_CNT, 16'h0005);
        far_u.pulse(1, 6);
        rd(OFF_CORE_CNT, v);
        cmp16("soft down", 16'h0004, v);
        // plain wrap with reload disabled
        wr(OFF_CORE_CTRL, cc & ~bit_of(TC_RELOAD));
        wr(OFF_CORE_CNT, CNT_MAX);
        far_u.pulse(1, 6);
        rd(OFF_CORE_CNT, v);
        cmp16("wrap to zero", CNT_RST, v);
        wr(OFF_IRQ_STAT, 16'h0002);
        rd(OFF_IRQ_STAT, v);
        cmp16("status cleared", 16'h0000, v);
        cmp1("irq cleared", 1'b0, irq_o);
        // capture on pin rise with clear, fall not selected
        wr(OFF_CORE_CTRL, CTRL_RST);
        wr(OFF_AUX_CTRL, CTRL_RST);
        wr(OFF_AUX_CNT, 16'h0ABC);
        wr(OFF_CAP_CTRL, {14'h0000, EDGE_RISE} | bit_of(CC_CLR));
        far_u.set_pin(4, 1'b1, 8);
        rd(OFF_CAPTURE_RELOAD_REG, v);
        cmp16("capture", 16'h0ABC, v);
        rd(OFF_AUX_CNT, v);
        cmp16("aux cleared", CNT_RST, v);
        rd(OFF_IRQ_STAT, v);
        cmp16("status capture", 16'h0004, v);
        cmp1("capture masked", 1'b0, irq_o);
        wr(OFF_AUX_CNT, 16'h0011);
        far_u.set_pin(4, 1'b0, 8);
        rd(OFF_CAPTURE_RELOAD_REG, v);
        cmp16("fall ignored", 16'h0ABC, v);
        // capture from the other module's count and direction inputs
        wr(OFF_CAP_CTRL, bit_of(CC_OCNT));
        wr(OFF_AUX_CNT, 16'h0055);
        far_u.set_pin(5, 1'b1, 8);
        rd(OFF_CAPTURE_RELOAD_REG, v);
        cmp16("other count capture", 16'h0055, v);
        wr(OFF_CAP_CTRL, bit_of(CC_ODIR));
        wr(OFF_AUX_CNT, 16'h0066);
        far_u.set_pin(6, 1'b1, 8);
        rd(OFF_CAPTURE_RELOAD_REG, v);
        cmp16("other dir capture", 16'h0066, v);
        rd(OFF_AUX_CNT, v);
        cmp16("aux kept", 16'h0066, v);
        // aux on its own pin, both edges, direction from its pin
        cc = bit_of(TC_RUN) | bit_of(TC_EXTCLK) | bit_of(TC_PINDIR)
           | ({14'h0000, EDGE_RISE | EDGE_FALL} << TC_EDGE_L);
        wr(OFF_AUX_CTRL, cc);
        wr(OFF_AUX_CNT, CNT_MAX);
        far_u.pulse(0, 6);
        rd(OFF_AUX_CNT, v);
        cmp16("aux both edges up", CNT_ONE, v);
        far_u.set_pin(2, 1'b1, 2);
        far_u.pulse(0, 6);
        rd(OFF_AUX_CNT, v);
        cmp16("aux pin down", CNT_MAX, v);
        rd(OFF_IRQ_STAT, v);
        cmp16("status aux", 16'h0005, v);
        final_report();
    end
endmodule
